// File: design/out_func_select.sv
// Functional notes
// - code 22 drives the output while the drive stands ready for a run.
// - code 28 drives the output from the timer's expiry signal.
// - code 29 drives the output from the delayed fault trip.
// - code 34 drives the output from the analog on/off compare.
// - code 35 drives the output as the brake release signal.
// - code 40 drives the output while energy buffering is active.
// - the transistor output has its own code, 14 (running) after reset.
// - each output's level is readable as one bit of a status word.
// - the trip function is available on the transistor and both relays.
// - a three-bit trip class field resets to 010.
// - relay two and its code exist only in the larger variant.
// - a trip asserts the trip outputs after a 0..100 s on delay.
// - trip removal releases them after a 0..100 s off delay.
// - class bit1 means undervolt, bit2 other trips, bit3 failed restart.
// - code 14 is on with run command and voltage out, off in dc braking.
//
// top of the output function select block with its apb3 slave
// assumes drive conditions come from logic on the same clock
`timescale 1ns/10ps
module out_func_select #(
  parameter bit          HAS_RELAY_TWO = 1'b1,
  parameter int unsigned TICK_CYCLES   = out_sel_pkg::TICK_CYCLES
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire out_sel_pkg::drive_cond_t cond,
  input  wire out_sel_pkg::trip_cause_t trip_cause,
  output logic                          relay_one_out,
  output logic                          relay_two_out,
  output logic                          open_collector_output,
  output logic                          irq
);

  // ==========================================================
  // registers
  logic [2:0]  trip_class_select_bits_ff;
  logic [5:0]  relay_one_function_code_ff;
  logic [5:0]  relay_two_function_code_ff;
  logic [5:0]  transistor_output_function_code_ff;
  logic [13:0] trip_assert_delay_ff;
  logic [13:0] trip_release_delay_ff;
  logic [2:0]  irq_status_ff;
  logic [2:0]  irq_enable_ff;
  logic [2:0]  out_state_ff;
  logic        trip_prev_ff;
  logic        ready_ff;
  logic        err_ff;
  logic [31:0] rdata_ff;
  logic        irq_ff;

  // ==========================================================
  // apb decode
  wire logic setup    = psel & ~penable;
  wire logic wr_fire  = psel & penable & pwrite & ready_ff;
  wire logic hit_cls  = (paddr == out_sel_pkg::OFF_TRIP_CLASS);
  wire logic hit_r1   = (paddr == out_sel_pkg::OFF_RELAY_ONE);
  wire logic hit_r2   = (paddr == out_sel_pkg::OFF_RELAY_TWO);
  wire logic hit_tr   = (paddr == out_sel_pkg::OFF_TRANSISTOR);
  wire logic hit_st   = (paddr == out_sel_pkg::OFF_OUT_STATE);
  wire logic hit_ad   = (paddr == out_sel_pkg::OFF_ASSERT_DLY);
  wire logic hit_rd   = (paddr == out_sel_pkg::OFF_RELEASE_DLY);
  wire logic hit_is   = (paddr == out_sel_pkg::OFF_IRQ_STATUS);
  wire logic hit_ic   = (paddr == out_sel_pkg::OFF_IRQ_CLEAR);
  wire logic hit_ie   = (paddr == out_sel_pkg::OFF_IRQ_ENABLE);
  wire logic mapped   = hit_cls | hit_r1 | (hit_r2 & HAS_RELAY_TWO) |
                        hit_tr | hit_st | hit_ad | hit_rd | hit_is |
                        hit_ic | hit_ie;

  // delay writes above 100.00 s saturate rather than wrap
  wire logic [13:0] wdly = (pwdata[31:14] != 18'h0 ||
                            pwdata[13:0] > out_sel_pkg::DELAY_MAX) ?
                           out_sel_pkg::DELAY_MAX : pwdata[13:0];

  wire logic [31:0] rd_mux =
    hit_cls ? {29'h0, trip_class_select_bits_ff} :
    hit_r1  ? {26'h0, relay_one_function_code_ff} :
    (hit_r2 & HAS_RELAY_TWO) ? {26'h0, relay_two_function_code_ff} :
    hit_tr  ? {26'h0, transistor_output_function_code_ff} :
    hit_st  ? {29'h0, out_state_ff} :
    hit_ad  ? {18'h0, trip_assert_delay_ff} :
    hit_rd  ? {18'h0, trip_release_delay_ff} :
    hit_is  ? {29'h0, irq_status_ff} :
    hit_ie  ? {29'h0, irq_enable_ff} : 32'h0;

  // one access cycle: answer is prepared during setup
  always_ff @(posedge clk) begin
    if (rst) begin
      ready_ff <= 1'b0;
      err_ff   <= 1'b0;
      rdata_ff <= 32'h0;
    end else begin
      ready_ff <= setup;
      err_ff   <= setup & ~mapped;
      rdata_ff <= (setup & ~pwrite) ? rd_mux : 32'h0;
    end
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge clk) begin
    if (rst) begin
      trip_class_select_bits_ff  <= out_sel_pkg::RST_TRIP_CLASS;
      relay_one_function_code_ff <= out_sel_pkg::RST_RELAY_ONE;
      relay_two_function_code_ff <= out_sel_pkg::RST_RELAY_TWO;
      transistor_output_function_code_ff <=
        out_sel_pkg::RST_TRANSISTOR;
      trip_assert_delay_ff  <= out_sel_pkg::RST_DELAY;
      trip_release_delay_ff <= out_sel_pkg::RST_DELAY;
      irq_enable_ff         <= out_sel_pkg::RST_IRQ_ENABLE;
    end else if (wr_fire) begin
      if (hit_cls) trip_class_select_bits_ff <= pwdata[2:0];
      if (hit_r1) relay_one_function_code_ff <= pwdata[5:0];
      if (hit_r2 & HAS_RELAY_TWO) begin
        relay_two_function_code_ff <= pwdata[5:0];
      end
      if (hit_tr) transistor_output_function_code_ff <= pwdata[5:0];
      if (hit_ad) trip_assert_delay_ff <= wdly;
      if (hit_rd) trip_release_delay_ff <= wdly;
      if (hit_ie) irq_enable_ff <= pwdata[2:0];
    end
  end

  // ==========================================================
  // trip qualification and delay
  // class bits gate causes
  wire logic trip_raw =
    (trip_class_select_bits_ff[0] & trip_cause.undervolt) |
    (trip_class_select_bits_ff[1] & trip_cause.other) |
    (trip_class_select_bits_ff[2] & trip_cause.restart_fail);

  logic tick;
  logic trip_out;

  tick_gen #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk     (clk),
    .rst     (rst),
    .tick_ff (tick)
  );

  trip_delay u_trip (
    .clk     (clk),
    .rst     (rst),
    .tick    (tick),
    .raw     (trip_raw),
    .on_dly  (trip_assert_delay_ff),
    .off_dly (trip_release_delay_ff),
    .out_ff  (trip_out)
  );

  // ==========================================================
  // output selection
  // code decode
  wire logic sel_r1 = out_sel_pkg::select_output(
    relay_one_function_code_ff, cond, trip_out);
  wire logic sel_r2 = HAS_RELAY_TWO & out_sel_pkg::select_output(
    relay_two_function_code_ff, cond, trip_out);
  wire logic sel_tr = out_sel_pkg::select_output(
    transistor_output_function_code_ff, cond, trip_out);
  wire logic [2:0] nxt_out_state = {sel_tr, sel_r2, sel_r1};

  // ==========================================================
  // interrupt status: trip rise, trip fall, any output change
  wire logic [2:0] ev = {
    nxt_out_state != out_state_ff,
    trip_prev_ff & ~trip_out,
    ~trip_prev_ff & trip_out
  };
  wire logic [2:0] clr = (wr_fire & hit_ic) ? pwdata[2:0] : 3'h0;
  // irq follows an enable write in the same cycle as the register
  wire logic [2:0] nxt_irq_enable = (wr_fire & hit_ie) ? pwdata[2:0] :
                                    irq_enable_ff;
  // a new event beats a clear in the same cycle
  wire logic [2:0] nxt_irq_status = (irq_status_ff & ~clr) | ev;

  always_ff @(posedge clk) begin
    if (rst) begin
      out_state_ff  <= 3'h0;
      trip_prev_ff  <= 1'b0;
      irq_status_ff <= 3'h0;
      irq_ff        <= 1'b0;
    end else begin
      out_state_ff  <= nxt_out_state;
      trip_prev_ff  <= trip_out;
      irq_status_ff <= nxt_irq_status;
      irq_ff        <= |(nxt_irq_status & nxt_irq_enable);
    end
  end

  assign relay_one_out         = out_state_ff[0];
  assign relay_two_out         = out_state_ff[1];
  assign open_collector_output = out_state_ff[2];
  assign irq                   = irq_ff;
  assign prdata                = rdata_ff;
  assign pready                = ready_ff;
  assign pslverr               = err_ff;

  // ==========================================================
  // checks
  property p_ready_code;
    @(posedge clk) disable iff (rst)
      (transistor_output_function_code_ff == out_sel_pkg::FN_READY)
      |=> open_collector_output == $past(cond.standby_ready);
  endproperty
  a_ready_code: assert property (p_ready_code)
    else $error("ready code not followed on transistor output");

  property p_timer_code;
    @(posedge clk) disable iff (rst)
      (relay_one_function_code_ff == out_sel_pkg::FN_TIMER)
      |=> relay_one_out == $past(cond.timer_out);
  endproperty
  a_timer_code: assert property (p_timer_code)
    else $error("timer code not followed on relay one");

  property p_trip_code;
    @(posedge clk) disable iff (rst)
      (relay_one_function_code_ff == out_sel_pkg::FN_TRIP)
      |=> relay_one_out == $past(trip_out);
  endproperty
  a_trip_code: assert property (p_trip_code)
    else $error("trip code not followed on relay one");

  property p_onoff_code;
    @(posedge clk) disable iff (rst)
      (transistor_output_function_code_ff == out_sel_pkg::FN_ON_OFF)
      |=> open_collector_output == $past(cond.analog_on);
  endproperty
  a_onoff_code: assert property (p_onoff_code)
    else $error("on/off code not followed");

  property p_brake_code;
    @(posedge clk) disable iff (rst)
      (relay_one_function_code_ff == out_sel_pkg::FN_BRAKE)
      |=> relay_one_out == $past(cond.brake_release);
  endproperty
  a_brake_code: assert property (p_brake_code)
    else $error("brake code not followed");

  property p_buffer_code;
    @(posedge clk) disable iff (rst)
      (transistor_output_function_code_ff == out_sel_pkg::FN_BUFFER)
      |=> open_collector_output == $past(cond.energy_buffering);
  endproperty
  a_buffer_code: assert property (p_buffer_code)
    else $error("buffering code not followed");

  property p_run_brake;
    @(posedge clk) disable iff (rst)
      (transistor_output_function_code_ff == out_sel_pkg::FN_RUN &&
       cond.dc_braking) |=> !open_collector_output;
  endproperty
  a_run_brake: assert property (p_run_brake)
    else $error("run output on during dc braking");

  property p_no_relay_two;
    @(posedge clk) disable iff (rst)
      !HAS_RELAY_TWO |-> !relay_two_out;
  endproperty
  a_no_relay_two: assert property (p_no_relay_two)
    else $error("relay two driven in small variant");

  property p_class_gate;
    @(posedge clk) disable iff (rst)
      (trip_class_select_bits_ff == 3'h0 &&
       trip_release_delay_ff == 14'h0) [*2] |-> !trip_out;
  endproperty
  a_class_gate: assert property (p_class_gate)
    else $error("trip qualified with all classes off");

  property p_apb_answer;
    @(posedge clk) disable iff (rst)
      (psel && !penable) |=> pready ##1 !pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("apb answer not a single access cycle");

  property p_irq_level;
    @(posedge clk) disable iff (rst)
      ##1 irq == |(irq_status_ff & irq_enable_ff);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt level disagrees with status");

  c_trip_seen: cover property (@(posedge clk) disable iff (rst)
    $rose(trip_out));
  c_trip_gone: cover property (@(posedge clk) disable iff (rst)
    $fell(trip_out));
  c_write_read: cover property (@(posedge clk) disable iff (rst)
    (wr_fire && hit_ad) ##[1:10] (pready && !pwrite && hit_ad));
  c_irq: cover property (@(posedge clk) disable iff (rst)
    $rose(irq));

endmodule : out_func_select

// File: design/out_sel_pkg.sv
// package for the output function select and trip delay block
// assumes one 125 MHz control clock and an apb3 register port
package out_sel_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] OFF_TRIP_CLASS = 8'h00;
  localparam logic [7:0] OFF_RELAY_ONE  = 8'h04;
  localparam logic [7:0] OFF_RELAY_TWO  = 8'h08;
  localparam logic [7:0] OFF_TRANSISTOR = 8'h0c;
  localparam logic [7:0] OFF_OUT_STATE  = 8'h10;
  localparam logic [7:0] OFF_ASSERT_DLY = 8'h14;
  localparam logic [7:0] OFF_RELEASE_DLY = 8'h18;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h1c;
  localparam logic [7:0] OFF_IRQ_CLEAR  = 8'h20;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h24;

  // ==========================================================
  // function codes
  localparam logic [5:0] FN_RUN     = 6'h0e;
  localparam logic [5:0] FN_READY   = 6'h16;
  localparam logic [5:0] FN_TIMER   = 6'h1c;
  localparam logic [5:0] FN_TRIP    = 6'h1d;
  localparam logic [5:0] FN_ON_OFF  = 6'h22;
  localparam logic [5:0] FN_BRAKE   = 6'h23;
  localparam logic [5:0] FN_BUFFER  = 6'h28;

  // ==========================================================
  // reset values and limits
  localparam logic [2:0]  RST_TRIP_CLASS = 3'h2;
  localparam logic [5:0]  RST_RELAY_ONE  = FN_TRIP;
  localparam logic [5:0]  RST_RELAY_TWO  = FN_RUN;
  localparam logic [5:0]  RST_TRANSISTOR = FN_RUN;
  localparam logic [13:0] RST_DELAY      = 14'h0000;
  localparam logic [13:0] DELAY_MAX      = 14'h2710;
  localparam logic [2:0]  RST_IRQ_ENABLE = 3'h0;

  // ==========================================================
  // timing: one delay unit is a 10 ms tick
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned TICK_MS       = 10;
  localparam int unsigned TICK_CYCLES   =
    (TICK_MS * 1000000) / CLK_PERIOD_NS;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic run_cmd;
    logic volt_out;
    logic dc_braking;
    logic standby_ready;
    logic timer_out;
    logic analog_on;
    logic brake_release;
    logic energy_buffering;
  } drive_cond_t;

  typedef struct packed {
    logic restart_fail;
    logic other;
    logic undervolt;
  } trip_cause_t;

  // maps a function code to an output level; unknown codes give off
  function automatic logic select_output(
    input logic [5:0]  code,
    input drive_cond_t c,
    input logic        trip
  );
    logic r;
    r = 1'b0;
    case (code)
      FN_RUN:    r = c.run_cmd & c.volt_out & ~c.dc_braking;
      FN_READY:  r = c.standby_ready;
      FN_TIMER:  r = c.timer_out;
      FN_TRIP:   r = trip;
      FN_ON_OFF: r = c.analog_on;
      FN_BRAKE:  r = c.brake_release;
      FN_BUFFER: r = c.energy_buffering;
      default:   r = 1'b0;
    endcase
    return r;
  endfunction : select_output

endpackage : out_sel_pkg

// File: design/tick_gen.sv
// fixed-period tick pulse for the trip delays
// assumes a free-running clock; tick is one cycle wide
`timescale 1ns/10ps
module tick_gen #(
  parameter int unsigned TICK_CYCLES = out_sel_pkg::TICK_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst,
  output logic      tick_ff
);
  logic [31:0] cnt_ff;
  wire logic   wrap = (cnt_ff == 32'(TICK_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff  <= 32'h0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= wrap ? 32'h0 : cnt_ff + 32'h1;
      tick_ff <= wrap;
    end
  end
endmodule : tick_gen

// File: design/trip_delay.sv
// on/off delay filter for the qualified trip level
// assumes tick is a one-cycle pulse every delay unit
`timescale 1ns/10ps
module trip_delay (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        tick,
  input  wire logic        raw,
  input  wire logic [13:0] on_dly,
  input  wire logic [13:0] off_dly,
  output logic             out_ff
);
  logic [13:0] cnt_ff;
  wire logic [13:0] limit  = raw ? on_dly : off_dly;
  wire logic        differ = (raw != out_ff);
  wire logic        expire = differ && (cnt_ff >= limit);
  wire logic [13:0] nxt_cnt = (!differ || expire) ? 14'h0 :
                              tick ? cnt_ff + 14'h1 : cnt_ff;

  // a change back before expiry restarts the count; the first
  // tick may be partial, so the wait is up to one tick short
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= 14'h0;
      out_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      out_ff <= expire ? raw : out_ff;
    end
  end

  property p_follow_only;
    @(posedge clk) disable iff (rst)
      $changed(out_ff) |-> out_ff == $past(raw);
  endproperty
  a_follow_only: assert property (p_follow_only)
    else $error("trip output moved away from its input");

  property p_zero_delay;
    @(posedge clk) disable iff (rst)
      (differ && limit == 14'h0) |=> out_ff == $past(raw);
  endproperty
  a_zero_delay: assert property (p_zero_delay)
    else $error("zero delay not taken on next edge");
endmodule : trip_delay

// File: dv/field_load.sv
// field wiring model: two relay contacts and a pulled-up transistor terminal
// assumes the drive outputs are active high levels on the bench clock
`timescale 1ns/10ps
module field_load (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       relay_one_out,
  input  wire logic       relay_two_out,
  input  wire logic       open_collector_output,
  output logic      [2:0] term_ff
);
  // ==========================================================
  // terminal levels
  // the transistor sinks current when on, so the pulled-up terminal
  // reads low while the output is asserted
  always_ff @(posedge clk) begin
    if (rst) begin
      term_ff <= 3'h4;
    end else begin
      term_ff <= {~open_collector_output, relay_two_out, relay_one_out};
    end
  end
endmodule : field_load

// File: dv/test_out_func_select.sv
// self-checking bench for the output function select block
// assumes the design package, modules and field_load are compiled first
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module test_out_func_select;
  localparam int unsigned TCK   = 4;
  localparam int unsigned LIMIT = 20000;
  logic                    clk;
  logic                    rst;
  logic                    psel;
  logic                    penable;
  logic                    pwrite;
  logic [7:0]              paddr;
  logic [31:0]             pwdata;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  out_sel_pkg::drive_cond_t cond;
  out_sel_pkg::trip_cause_t trip_cause;
  logic                    relay_one_out;
  logic                    relay_two_out;
  logic                    open_collector_output;
  logic                    irq;
  logic [2:0]              term;
  int unsigned             fails;
  int unsigned             n_checks;
  int unsigned             cyc;

  out_func_select #(.HAS_RELAY_TWO(1'b1), .TICK_CYCLES(TCK)) u_dut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cond(cond),
    .trip_cause(trip_cause), .relay_one_out(relay_one_out),
    .relay_two_out(relay_two_out),
    .open_collector_output(open_collector_output), .irq(irq)
  );

  field_load u_load (
    .clk(clk), .rst(rst), .relay_one_out(relay_one_out),
    .relay_two_out(relay_two_out),
    .open_collector_output(open_collector_output), .term_ff(term)
  );

  // ==========================================================
  // clock and watchdog
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      fails++;
      report_and_stop();
    end
  end

  // ==========================================================
  // bus and helper tasks
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(a, 1'b1, d, q, e);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [31:0] x);
    logic [31:0] q;
    logic        e;
    apb(a, 1'b0, 32'h0, q, e);
    `CHK(nm, x, q)
  endtask : rd_chk

  task automatic drv(input logic [7:0] m);
    @(posedge clk);
    cond <= out_sel_pkg::drive_cond_t'(m);
  endtask : drv

  task automatic settle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic cause(input logic [2:0] c);
    @(posedge clk);
    trip_cause <= out_sel_pkg::trip_cause_t'(c);
    settle();
  endtask : cause

  // ==========================================================
  // scenarios
  task automatic test_reset();
    logic [31:0] q;
    logic        e;
    rd_chk("trip_class", out_sel_pkg::OFF_TRIP_CLASS, 32'h2);
    rd_chk("relay_one_code", out_sel_pkg::OFF_RELAY_ONE, 32'h1d);
    rd_chk("relay_two_code", out_sel_pkg::OFF_RELAY_TWO, 32'h0e);
    rd_chk("transistor_code", out_sel_pkg::OFF_TRANSISTOR, 32'h0e);
    rd_chk("on_delay", out_sel_pkg::OFF_ASSERT_DLY, 32'h0);
    rd_chk("off_delay", out_sel_pkg::OFF_RELEASE_DLY, 32'h0);
    rd_chk("irq_enable", out_sel_pkg::OFF_IRQ_ENABLE, 32'h0);
    rd_chk("irq_status", out_sel_pkg::OFF_IRQ_STATUS, 32'h0);
    apb(8'h28, 1'b0, 32'h0, q, e);
    `CHK("unmapped_err", 1'b1, e)
    `CHK("unmapped_data", 32'h0, q)
  endtask : test_reset

  task automatic test_functions();
    logic [5:0] codes [8] = '{out_sel_pkg::FN_READY,
      out_sel_pkg::FN_TIMER, out_sel_pkg::FN_ON_OFF,
      out_sel_pkg::FN_BRAKE, out_sel_pkg::FN_BUFFER,
      out_sel_pkg::FN_RUN, out_sel_pkg::FN_RUN, 6'h3f};
    logic [7:0] masks [8] = '{8'h10, 8'h08, 8'h04, 8'h02, 8'h01,
                               8'hc0, 8'he0, 8'hff};
    logic       x;
    for (int i = 0; i < 8; i++) begin
      wr(out_sel_pkg::OFF_TRANSISTOR, {26'h0, codes[i]});
      wr(out_sel_pkg::OFF_RELAY_ONE, {26'h0, codes[i]});
      wr(out_sel_pkg::OFF_RELAY_TWO, {26'h0, codes[i]});
      x = (i < 6);
      drv(masks[i]);
      settle();
      `CHK("oc_on", x, open_collector_output)
      `CHK("relay_one_on", x, relay_one_out)
      `CHK("relay_two_on", x, relay_two_out)
      `CHK("oc_terminal", ~x, term[2])
      `CHK("relay_terminals", {x, x}, term[1:0])
      rd_chk("bitmap", out_sel_pkg::OFF_OUT_STATE, {29'h0, x, x, x});
      drv(~masks[i]);
      settle();
      `CHK("oc_off", 1'b0, open_collector_output)
      `CHK("relays_off", 2'b00, {relay_two_out, relay_one_out})
    end
    drv(8'h00);
  endtask : test_functions

  task automatic test_trip();
    wr(out_sel_pkg::OFF_TRANSISTOR, {26'h0, out_sel_pkg::FN_TRIP});
    wr(out_sel_pkg::OFF_RELAY_ONE, {26'h0, out_sel_pkg::FN_TRIP});
    wr(out_sel_pkg::OFF_IRQ_ENABLE, 32'h1);
    cause(3'b001);
    `CHK("uv_masked", 1'b0, relay_one_out)
    `CHK("irq_idle", 1'b0, irq)
    cause(3'b010);
    `CHK("trip_relay", 1'b1, relay_one_out)
    `CHK("trip_oc", 1'b1, open_collector_output)
    `CHK("irq_rise", 1'b1, irq)
    rd_chk("status_rise", out_sel_pkg::OFF_IRQ_STATUS, 32'h5);
    rd_chk("bitmap_trip", out_sel_pkg::OFF_OUT_STATE, 32'h5);
    wr(out_sel_pkg::OFF_IRQ_CLEAR, 32'h7);
    @(negedge clk);
    `CHK("irq_cleared", 1'b0, irq)
    wr(out_sel_pkg::OFF_TRIP_CLASS, 32'h5);
    settle();
    `CHK("other_off", 1'b0, relay_one_out)
    `CHK("irq_masked", 1'b0, irq)
    rd_chk("status_fall", out_sel_pkg::OFF_IRQ_STATUS, 32'h6);
    cause(3'b100);
    `CHK("restart_trip", 1'b1, relay_one_out)
    cause(3'b001);
    `CHK("uv_trip", 1'b1, relay_one_out)
    `CHK("trip_terminal", 1'b1, term[0])
    wr(out_sel_pkg::OFF_TRIP_CLASS, 32'h0);
    settle();
    `CHK("all_masked", 1'b0, relay_one_out)
    cause(3'b000);
    wr(out_sel_pkg::OFF_TRIP_CLASS, 32'h5);
    wr(out_sel_pkg::OFF_IRQ_CLEAR, 32'h7);
  endtask : test_trip

  task automatic test_delays();
    int unsigned n;
    wr(out_sel_pkg::OFF_ASSERT_DLY, 32'hffff);
    rd_chk("on_delay_sat", out_sel_pkg::OFF_ASSERT_DLY, 32'h2710);
    wr(out_sel_pkg::OFF_ASSERT_DLY, 32'h3);
    wr(out_sel_pkg::OFF_RELEASE_DLY, 32'h2);
    @(posedge clk);
    trip_cause <= out_sel_pkg::trip_cause_t'(3'b100);
    n = 0;
    while (relay_one_out !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    `CHK("on_delay", 1'b1, n >= 2 * TCK && n <= 3 * TCK + 4)
    @(posedge clk);
    trip_cause <= out_sel_pkg::trip_cause_t'(3'b000);
    n = 0;
    while (relay_one_out !== 1'b0 && n < 40) begin
      @(negedge clk);
      n++;
    end
    `CHK("off_delay", 1'b1, n >= TCK && n <= 2 * TCK + 4)
  endtask : test_delays

  // ==========================================================
  // verdict
  task automatic report_and_stop();
    if (fails == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cond = '0;
    trip_cause = '0;
    fails = 0;
    n_checks = 0;
    cyc = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    test_reset();
    test_functions();
    test_trip();
    test_delays();
    report_and_stop();
  end
endmodule : test_out_func_select
